// File: ddrcal_ctrl.sv
// Our own choices: the AHB-Lite slave port and the register addresses.
`include "ddrcal_map.svh"

// Operation
// - writes work before calibration; reads need delay
// - ECC corrects single, detects double bit errors
// - ECC: data lane, check lane, lower half only
// - forward ECC events when report enables set
// - upper map enable opens memory beyond 512MB
module ddrcal_ctrl #(
   parameter int DLY_W = `DDRCAL_DLY_W,
   parameter int RD_TMO_CYC = `DDRCAL_RD_TMO_CYC
) (
   // ahb-lite slave
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // memory side
   input wire logic mem_init_done,
   input wire logic mem_rd_strobe,
   input wire ddrcal_pkg::ddrcal_beat_t mem_rd_beat,
   output ddrcal_pkg::ddrcal_mem_req_t mem_req,
   // ecc events toward the system bus
   output logic ecc_corrected_event,
   output logic ecc_uncorrectable_event
);
   import ddrcal_pkg::*;

   if (DLY_W < 1 || DLY_W > 8)
   begin : g_bad_dly
      $error("DLY_W must be 1 to 8");
   end
   if (RD_TMO_CYC < 2 || RD_TMO_CYC > 4096)
   begin : g_bad_tmo
      $error("RD_TMO_CYC must be 2 to 4096");
   end

   localparam int TMO_W = $clog2(RD_TMO_CYC + 1);
   localparam logic [DLY_W-1:0] DLY_MAX = '1;
   localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(RD_TMO_CYC - 1);

   ddrcal_state_t state;
   ddrcal_cfg_t cfg;
   ddrcal_stat_t stat;
   logic [1:0][DLY_W-1:0] dly;
   logic [31:0] dp_addr;
   logic dp_reg_wr;
   logic dp_byte;
   logic [TMO_W-1:0] tmo_cnt;
   logic [2:0] strb_sync;
   logic [1:0] init_sync;
   ddrcal_beat_t beat_s1;
   ddrcal_beat_t beat_s2;
   logic [1:0] lane_got;
   logic [15:0] lane_bytes;
   logic [7:0] sd_data;
   logic [7:0] sd_check_gen;
   logic [7:0] sd_fixed;
   logic sd_single;
   logic sd_double;
   logic [31:0] reg_rd_val;
   logic [31:0] rd_word;
   logic [1:0] rd_need;
   logic strb_edge;
   logic addr_take;
   logic mem_hit;
   logic rd_ok;
   logic rd_timeout;
   logic rd_done;
   logic rd_ecc_done;
   logic stat_wr;

   function automatic logic is_reg(input logic [31:0] a, input logic [7:0] ofs);
      return (a[31:8] == `DDRCAL_REG_TOP) && (a[7:0] == ofs);
   endfunction

   function automatic logic in_mem(input logic [31:0] a, input logic upper);
      if (upper)
         return (a >= `DDRCAL_MEM_BASE) && (a < `DDRCAL_MEM_HIGH_END);
      return (a >= `DDRCAL_MEM_BASE) && (a < `DDRCAL_MEM_LOW_END);
   endfunction

   function automatic logic [28:0] beat_index(input logic [31:0] a, input logic ecc);
      logic [31:0] off;
      off = a - `DDRCAL_MEM_BASE;
      return ecc ? off[28:0] : off[29:1];
   endfunction

   assign addr_take = hsel && htrans[1] && hready;
   // ecc hides the upper half of the memory window
   assign mem_hit = in_mem(haddr, cfg.upper_map_enable && !cfg.check_code_enable);
   assign strb_edge = strb_sync[1] && !strb_sync[2];
   assign rd_need = (cfg.byte_lane_count_sel || cfg.check_code_enable) ? 2'b11 : 2'b01;
   assign rd_ok = (lane_got & rd_need) == rd_need;
   assign rd_timeout = tmo_cnt == TMO_LAST;
   assign rd_done = (state == ST_MEM_RD) && (rd_ok || rd_timeout);
   assign rd_ecc_done = rd_done && rd_ok && cfg.check_code_enable;
   assign stat_wr = dp_reg_wr && is_reg(dp_addr, `DDRCAL_OFS_STATUS);

   // synchronisers for pins from the memory side
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         strb_sync <= 3'h0;
         init_sync <= 2'h0;
         beat_s1 <= '0;
         beat_s2 <= '0;
      end
      else
      begin
         strb_sync <= {strb_sync[1:0], mem_rd_strobe};
         init_sync <= {init_sync[0], mem_init_done};
         beat_s1 <= mem_rd_beat;
         beat_s2 <= beat_s1;
      end
   end

   // per-lane capture, delayed from the strobe edge by the lane delay
   for (genvar l = 0; l < 2; l++)
   begin : g_lane
      logic busy;
      logic got;
      logic [DLY_W-1:0] cnt;
      logic [7:0] byte_q;
      logic [DLY_W-1:0] dly_start;
      logic [DLY_W:0] since;

      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
         begin
            busy <= 1'b0;
            got <= 1'b0;
            cnt <= '0;
            byte_q <= 8'h00;
            dly_start <= '0;
            since <= '0;
         end
         else if (state != ST_MEM_RD)
         begin
            busy <= 1'b0;
            got <= 1'b0;
         end
         else if (busy)
         begin
            since <= since + 1'b1;
            if (cnt == '0)
            begin
               byte_q <= beat_s2[8*l +: 8];
               got <= 1'b1;
               busy <= 1'b0;
            end
            else
               cnt <= cnt - 1'b1;
         end
         else if (!got && strb_edge)
         begin
            busy <= 1'b1;
            cnt <= dly[l];
            dly_start <= dly[l];
            since <= '0;
         end
      end

      assign lane_got[l] = got;
      assign lane_bytes[8*l +: 8] = byte_q;

      a_delay_applied: assert property (@(posedge hclk) disable iff (!hresetn)
         (busy && cnt == '0) |-> since == {1'b0, dly_start})
         else $error("capture not at programmed strobe delay");
   end

   ddrcal_secded u_secded (
      .data(sd_data),
      .check_in(lane_bytes[15:8]),
      .check_gen(sd_check_gen),
      .fixed(sd_fixed),
      .single_err(sd_single),
      .double_err(sd_double)
   );

   // read data assembly and ecc source select
   always_comb
   begin
      logic [31:0] sh;
      logic [15:0] beat;
      sh = hwdata >> {dp_addr[1:0], 3'b000};
      beat = {lane_bytes[15:8] & {8{cfg.byte_lane_count_sel}}, lane_bytes[7:0]};
      sd_data = (state == ST_MEM_WR) ? sh[7:0] : lane_bytes[7:0];
      if (!rd_ok)
         rd_word = 32'h00000000;
      else if (cfg.check_code_enable)
         rd_word = {24'h000000, sd_fixed} << {dp_addr[1:0], 3'b000};
      else
         rd_word = dp_addr[1] ? {beat, 16'h0000} : {16'h0000, beat};
   end

   always_comb
   begin
      reg_rd_val = 32'h00000000;
      if (is_reg(dp_addr, `DDRCAL_OFS_CONFIG))
         reg_rd_val = {26'h0000000, cfg};
      else if (is_reg(dp_addr, `DDRCAL_OFS_DLY0))
         reg_rd_val = {{(32-DLY_W){1'b0}}, dly[0]};
      else if (is_reg(dp_addr, `DDRCAL_OFS_DLY1))
         reg_rd_val = {{(32-DLY_W){1'b0}}, dly[1]};
      else if (is_reg(dp_addr, `DDRCAL_OFS_STATUS))
         reg_rd_val = {27'h0000000, stat};
   end

   // bus state machine
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= ST_IDLE;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         dp_addr <= 32'h00000000;
         dp_reg_wr <= 1'b0;
         mem_req <= '0;
         dp_byte <= 1'b0;
         tmo_cnt <= '0;
      end
      else
      begin
         mem_req.valid <= 1'b0;
         dp_reg_wr <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (addr_take)
               begin
                  dp_addr <= haddr;
                  // size is only valid in the address phase
                  dp_byte <= (hsize == 3'h0);
                  if (mem_hit && hwrite)
                  begin
                     hreadyout <= 1'b0;
                     state <= ST_MEM_WR;
                  end
                  else if (mem_hit)
                  begin
                     hreadyout <= 1'b0;
                     mem_req.valid <= 1'b1;
                     mem_req.we <= 1'b0;
                     mem_req.addr <= beat_index(haddr, cfg.check_code_enable);
                     tmo_cnt <= '0;
                     state <= ST_MEM_RD;
                  end
                  else if (hwrite)
                     dp_reg_wr <= 1'b1;
                  else
                  begin
                     hreadyout <= 1'b0;
                     state <= ST_REG_RD;
                  end
               end
            end
            ST_REG_RD:
            begin
               hrdata <= reg_rd_val;
               hreadyout <= 1'b1;
               state <= ST_IDLE;
            end
            ST_MEM_WR:
            begin
               // writes never depend on the read strobe delay
               mem_req.valid <= 1'b1;
               mem_req.we <= 1'b1;
               mem_req.addr <= beat_index(dp_addr, cfg.check_code_enable);
               if (cfg.check_code_enable)
               begin
                  mem_req.wdata <= {sd_check_gen, sd_data};
                  mem_req.lane_wen <= 2'b11;
               end
               else
               begin
                  mem_req.wdata <= dp_addr[1] ? hwdata[31:16] : hwdata[15:0];
                  mem_req.lane_wen <= 2'b11;
                  if (dp_byte)
                     mem_req.lane_wen <= dp_addr[0] ? 2'b10 : 2'b01;
               end
               hreadyout <= 1'b1;
               state <= ST_IDLE;
            end
            ST_MEM_RD:
            begin
               tmo_cnt <= tmo_cnt + 1'b1;
               if (rd_done)
               begin
                  hrdata <= rd_word;
                  hreadyout <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default:
            begin
               hreadyout <= 1'b1;
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // software registers, written at the end of the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg <= `DDRCAL_CFG_RST;
         dly[0] <= DLY_W'(`DDRCAL_DLY_RST);
         dly[1] <= DLY_W'(`DDRCAL_DLY_RST);
      end
      else if (dp_reg_wr)
      begin
         if (is_reg(dp_addr, `DDRCAL_OFS_CONFIG))
            cfg <= hwdata[5:0];
         else if (is_reg(dp_addr, `DDRCAL_OFS_DLY0))
            dly[0] <= hwdata[DLY_W-1:0];
         else if (is_reg(dp_addr, `DDRCAL_OFS_DLY1))
            dly[1] <= hwdata[DLY_W-1:0];
      end
   end

   // status and ecc event forwarding; a new event beats a clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stat <= '0;
         ecc_corrected_event <= 1'b0;
         ecc_uncorrectable_event <= 1'b0;
      end
      else
      begin
         stat.init_done <= init_sync[1];
         stat.dly_at_max <= (dly[0] == DLY_MAX) || (dly[1] == DLY_MAX);
         stat.cor_seen <= (rd_ecc_done && sd_single) || (stat.cor_seen && !(stat_wr && hwdata[1]));
         stat.unc_seen <= (rd_ecc_done && sd_double) || (stat.unc_seen && !(stat_wr && hwdata[2]));
         stat.rd_timeout <= (rd_done && !rd_ok) || (stat.rd_timeout && !(stat_wr && hwdata[3]));
         ecc_corrected_event <= rd_ecc_done && sd_single && cfg.corrected_report_enable;
         ecc_uncorrectable_event <= rd_ecc_done && sd_double && cfg.uncorrectable_report_enable;
      end
   end

   sequence seq_unc_cause;
      rd_ecc_done && sd_double && cfg.uncorrectable_report_enable;
   endsequence

   sequence seq_unc_pulse;
      ecc_uncorrectable_event ##1 !ecc_uncorrectable_event;
   endsequence

   a_write_no_cal: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_MEM_WR) |=> mem_req.valid && mem_req.we && hreadyout)
      else $error("memory write not issued at once");
   a_ecc_single_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ecc_done && sd_single) |=> stat.cor_seen && hreadyout)
      else $error("single bit error not flagged");
   a_ecc_double_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ecc_done && sd_double) |=> stat.unc_seen && !ecc_corrected_event)
      else $error("double bit error not flagged");
   a_ecc_lane_use: assert property (@(posedge hclk) disable iff (!hresetn)
      (mem_req.valid && mem_req.we && $past(cfg.check_code_enable)) |-> mem_req.lane_wen == 2'b11)
      else $error("ecc write must use both lanes");
   a_ecc_lower_half: assert property (@(posedge hclk) disable iff (!hresetn)
      (addr_take && cfg.check_code_enable && haddr >= `DDRCAL_MEM_LOW_END
       && haddr < `DDRCAL_MEM_HIGH_END) |=> !mem_req.valid ##1 hreadyout)
      else $error("upper half reached with ecc on");
   a_unc_report: assert property (@(posedge hclk) disable iff (!hresetn)
      seq_unc_cause |=> seq_unc_pulse)
      else $error("uncorrectable event not forwarded");
   a_cor_gated: assert property (@(posedge hclk) disable iff (!hresetn)
      ecc_corrected_event |-> $past(cfg.corrected_report_enable) && $past(sd_single))
      else $error("corrected event without cause");
   a_upper_map_open: assert property (@(posedge hclk) disable iff (!hresetn)
      (addr_take && !hwrite && cfg.upper_map_enable && !cfg.check_code_enable
       && haddr >= `DDRCAL_MEM_LOW_END && haddr < `DDRCAL_MEM_HIGH_END)
      |=> mem_req.valid && !mem_req.we)
      else $error("upper map access not issued");

endmodule // ddrcal_ctrl

// File: ddrcal_map.svh
`ifndef DDRCAL_MAP_SVH
`define DDRCAL_MAP_SVH

// register offsets inside the control window
`define DDRCAL_OFS_CONFIG 8'h00
`define DDRCAL_OFS_DLY0 8'h04
`define DDRCAL_OFS_DLY1 8'h08
`define DDRCAL_OFS_STATUS 8'h0C

// address windows
`define DDRCAL_REG_TOP 24'h000000
`define DDRCAL_MEM_BASE 32'h20000000
`define DDRCAL_MEM_LOW_END 32'h40000000
`define DDRCAL_MEM_HIGH_END 32'h60000000

// reset values
`define DDRCAL_CFG_RST 6'h00
`define DDRCAL_DLY_RST 8'h00

// timing
`define DDRCAL_CLK_NS 5
`define DDRCAL_RD_TMO_NS 5120
`define DDRCAL_RD_TMO_CYC (`DDRCAL_RD_TMO_NS / `DDRCAL_CLK_NS)
`define DDRCAL_DLY_W 6

`endif

// File: ddrcal_mem_model.sv
module ddrcal_mem_model
   import ddrcal_pkg::*;
(
   // clock, request and error flip mask
   input wire logic hclk,
   input wire ddrcal_pkg::ddrcal_mem_req_t mem_req,
   input wire logic [7:0] flip,
   // toward the controller, and a write count for the testbench
   output logic mem_init_done,
   output logic mem_rd_strobe,
   output ddrcal_pkg::ddrcal_beat_t mem_rd_beat,
   output logic [7:0] wr_count
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [64];
   logic [15:0] cur;
   logic [15:0] nxt;
   logic lclk = 1'b0;
   always #62.5 lclk = ~lclk;
   initial
   begin
      mem_init_done = 1'b0;
      mem_rd_strobe = 1'b0;
      mem_rd_beat = 16'h5A5A;
      wr_count = 8'h00;
      foreach (mem[i]) mem[i] = 16'h0000;
      #300 mem_init_done = 1'b1;
   end
   // writes land with no calibration
   always @(posedge hclk)
   begin
      if (mem_req.valid && mem_req.we)
      begin
         if (mem_req.lane_wen[0]) mem[mem_req.addr[5:0]][7:0] <= mem_req.wdata[7:0];
         if (mem_req.lane_wen[1]) mem[mem_req.addr[5:0]][15:8] <= mem_req.wdata[15:8];
         wr_count <= wr_count + 8'h01;
      end
   end
   // read frame: one strobe pulse, each lane valid only in its own window
   always @(posedge hclk)
   begin
      if (mem_req.valid && !mem_req.we)
      begin
         cur = mem[mem_req.addr[5:0]];
         nxt = mem[mem_req.addr[5:0] + 6'h01];
         @(posedge lclk);
         // step off the hclk edge; frame ends before the next request can come
         #1;
         mem_rd_strobe = 1'b1;
         for (int t = 0; t < 13; t++)
         begin
            if (t == 12) mem_rd_strobe = 1'b0;
            mem_rd_beat.lane0 = t < 4 ? ~cur[7:0] : t < 10 ? cur[7:0] ^ flip : nxt[7:0];
            mem_rd_beat.lane1 = t < 6 ? ~cur[15:8] : t < 12 ? cur[15:8] : nxt[15:8];
            #5;
         end
         mem_rd_beat = ~mem_rd_beat;
      end
   end
endmodule // ddrcal_mem_model

// File: ddrcal_pkg.sv
package ddrcal_pkg;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_REG_RD = 4'h2,
      ST_MEM_WR = 4'h4,
      ST_MEM_RD = 4'h8
   } ddrcal_state_t;

   typedef struct packed {
      logic upper_map_enable;
      logic uncorrectable_report_enable;
      logic corrected_report_enable;
      logic check_code_enable;
      logic xfer_size;
      logic byte_lane_count_sel;
   } ddrcal_cfg_t;

   typedef struct packed {
      logic dly_at_max;
      logic rd_timeout;
      logic unc_seen;
      logic cor_seen;
      logic init_done;
   } ddrcal_stat_t;

   typedef struct packed {
      logic valid;
      logic we;
      logic [1:0] lane_wen;
      logic [28:0] addr;
      logic [15:0] wdata;
   } ddrcal_mem_req_t;

   typedef struct packed {
      logic [7:0] lane1;
      logic [7:0] lane0;
   } ddrcal_beat_t;

endpackage

// File: ddrcal_secded.sv
module ddrcal_secded (
   // byte and check word in
   input wire logic [7:0] data,
   input wire logic [7:0] check_in,
   // results
   output logic [7:0] check_gen,
   output logic [7:0] fixed,
   output logic single_err,
   output logic double_err
);

   localparam logic [3:0] POS [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC};

   function automatic logic [3:0] pos_xor(input logic [7:0] d);
      logic [3:0] acc;
      acc = 4'h0;
      for (int i = 0; i < 8; i++)
      begin
         if (d[i])
            acc = acc ^ POS[i];
      end
      return acc;
   endfunction

   // hamming code over twelve positions plus overall parity
   always_comb
   begin
      logic [3:0] syn;
      logic par;
      syn = 4'h0;
      par = 1'b0;
      check_gen = {3'h0, ^data ^ ^pos_xor(data), pos_xor(data)};
      syn = pos_xor(data) ^ check_in[3:0];
      par = ^data ^ ^check_in[4:0];
      fixed = data;
      if (par)
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (syn == POS[i])
               fixed[i] = ~data[i];
         end
      end
      single_err = par;
      double_err = (syn != 4'h0) && !par;
   end

endmodule // ddrcal_secded

// File: testbench.sv
`include "ddrcal_map.svh"

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] A_CFG = {`DDRCAL_REG_TOP, `DDRCAL_OFS_CONFIG};
   localparam logic [31:0] A_D0 = {`DDRCAL_REG_TOP, `DDRCAL_OFS_DLY0};
   localparam logic [31:0] A_D1 = {`DDRCAL_REG_TOP, `DDRCAL_OFS_DLY1};
   localparam logic [31:0] A_ST = {`DDRCAL_REG_TOP, `DDRCAL_OFS_STATUS};
   localparam logic [31:0] MB = `DDRCAL_MEM_BASE;
   localparam logic [31:0] HI = 32'h40000040;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic mem_init_done;
   logic mem_rd_strobe;
   logic cev;
   logic uev;
   ddrcal_pkg::ddrcal_beat_t mem_rd_beat;
   ddrcal_pkg::ddrcal_mem_req_t mem_req;
   logic [7:0] flip = 8'h00;
   logic [7:0] wr_count;
   logic [7:0] c;
   logic [31:0] r;
   int fail_count = 0;
   int n_tests = 0;
   int n_cor = 0;
   int n_unc = 0;
   int d0;
   int d1;
   always #2.5 hclk = ~hclk;
   ddrcal_ctrl #(.RD_TMO_CYC(64)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .mem_init_done(mem_init_done), .mem_rd_strobe(mem_rd_strobe),
      .mem_rd_beat(mem_rd_beat), .mem_req(mem_req),
      .ecc_corrected_event(cev), .ecc_uncorrectable_event(uev)
   );
   ddrcal_mem_model mem_u (
      .hclk(hclk), .mem_req(mem_req), .flip(flip), .mem_init_done(mem_init_done),
      .mem_rd_strobe(mem_rd_strobe), .mem_rd_beat(mem_rd_beat), .wr_count(wr_count)
   );
   // count event pulses toward the system bus
   always @(posedge hclk)
   begin
      if (cev === 1'b1) n_cor++;
      if (uev === 1'b1) n_unc++;
   end
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("counts: %0d compares, %0d mismatches", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // software read window search over one or two lanes
   task automatic cal(input int lanes);
      logic [7:0] tgt;
      logic ch;
      d0 = 0;
      d1 = 0;
      xfer(1'b1, A_D0, 32'h0);
      xfer(1'b1, A_D1, 32'h0);
      for (int ph = 0; ph < 2; ph++)
      begin
         tgt = ph ? 8'h00 : 8'hFF;
         ch = 1'b1;
         while (ch)
         begin
            ch = 1'b0;
            xfer(1'b0, MB, 32'h0);
            if (r[7:0] !== tgt && d0 < 63)
            begin
               d0++;
               ch = 1'b1;
            end
            if (lanes == 2 && r[15:8] !== tgt && d1 < 63)
            begin
               d1++;
               ch = 1'b1;
            end
            xfer(1'b1, A_D0, 32'(d0));
            xfer(1'b1, A_D1, 32'(d1));
         end
      end
      d0 -= 3;
      if (lanes == 2) d1 -= 3;
      xfer(1'b1, A_D0, 32'(d0));
      xfer(1'b1, A_D1, 32'(d1));
   endtask
   task automatic ecc_rd(input logic [7:0] f, input int ec, input int eu, input logic [31:0] ew);
      flip <= f;
      xfer(1'b0, MB + 32'h3, 32'h0);
      repeat (2) @(posedge hclk);
      check(n_cor, ec);
      check(n_unc, eu);
      check(r, ew);
      check(hresp, 1'b0);
   endtask
   initial
   begin
      #200000;
      fail_count++;
      end_sim();
   end
   initial
   begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, A_CFG, 32'h0);
      check(r, 32'h0);
      xfer(1'b0, A_D1, 32'h0);
      check(r, 32'h0);
      xfer(1'b1, 32'h80, 32'hFFFFFFFF);
      xfer(1'b0, 32'h80, 32'h0);
      check(r, 32'h0);
      xfer(1'b1, A_D0, 32'h2A);
      xfer(1'b0, A_D0, 32'h0);
      check(r, 32'h2A);
      for (int i = 0; i < 100 && r[0] !== 1'b1; i++) xfer(1'b0, A_ST, 32'h0);
      check(r[0], 1'b1);
      $display("test registers done");
      xfer(1'b1, A_CFG, 32'h0);
      xfer(1'b1, MB, 32'hFF);
      cal(1);
      check(d0, 6);
      xfer(1'b0, A_D0, 32'h0);
      check(r, 32'h6);
      xfer(1'b0, MB, 32'h0);
      check(r & 32'hFFFF, 32'hFF);
      $display("test one lane done");
      xfer(1'b1, A_CFG, 32'h1);
      xfer(1'b1, MB, 32'hFFFF);
      xfer(1'b1, MB + 32'h4, 32'h0);
      cal(2);
      check(d0, 6);
      check(d1, 8);
      xfer(1'b1, MB + 32'h8, 32'h1234);
      xfer(1'b0, MB + 32'h8, 32'h0);
      check(r & 32'hFFFF, 32'h1234);
      hsize <= 3'h0;
      xfer(1'b1, MB + 32'h9, 32'h0000AB00);
      hsize <= 3'h2;
      xfer(1'b0, MB + 32'h8, 32'h0);
      check(r & 32'hFFFF, 32'hAB34);
      $display("test two lanes done");
      c = wr_count;
      xfer(1'b1, HI, 32'h7);
      @(posedge hclk);
      check(wr_count, c);
      xfer(1'b1, A_CFG, 32'h21);
      xfer(1'b1, HI, 32'h7);
      @(posedge hclk);
      check(wr_count, c + 8'h01);
      xfer(1'b0, HI, 32'h0);
      check(r, 32'h7);
      $display("test upper map done");
      xfer(1'b1, A_CFG, 32'h3D);
      xfer(1'b0, A_CFG, 32'h0);
      check(r, 32'h3D);
      c = wr_count;
      xfer(1'b1, HI, 32'h7);
      @(posedge hclk);
      check(wr_count, c);
      xfer(1'b1, MB + 32'h3, 32'hAB000000);
      ecc_rd(8'h00, 0, 0, 32'hAB000000);
      ecc_rd(8'h01, 1, 0, 32'hAB000000);
      ecc_rd(8'h81, 1, 1, 32'h2A000000);
      xfer(1'b1, A_CFG, 32'h5);
      ecc_rd(8'h01, 1, 1, 32'hAB000000);
      flip <= 8'h00;
      $display("test check code done");
      end_sim();
   end
endmodule // testbench
